// File: rtl/sync_and_serial_strobe_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

module sync_and_serial_strobe_ctrl
  import sync_strobe_pkg::*;
#(
  parameter int SYNC_LONG  = SYNC_LONG_LOG2,
  parameter int SYNC_SHORT = SYNC_SHORT_LOG2
)
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              cs_n,
  input  wire logic              rd_wr_n,
  input  wire logic [3:0]        addr,
  input  wire logic [7:0]        data_in,
  output logic      [7:0]        data_out,
  output logic                   data_oe_n,
  input  wire logic              sys_sync_in_n,
  input  wire logic              accum_sync_in_n,
  input  wire logic              frame_next,
  output logic      [TUNE_W-1:0] tuning_word,
  output logic                   accum_load,
  output logic                   diag_reinit,
  output logic                   sync_out_n,
  output logic                   bit_shift,
  output logic                   bit_strobe,
  output logic                   frame_strobe
);

  generate
    if (SYNC_SHORT < 1 || SYNC_LONG <= SYNC_SHORT || SYNC_LONG > 31)
    begin : g_bad_sync
      $error("sync counter widths out of range");
    end
    // The slowest rate needs a count of two to the largest rate field value
    if (BITCNT_W < (1 << RATE_W) - 1)
    begin : g_bad_bitcnt
      $error("bit counter too narrow for the rate field");
    end
  endgenerate

  function automatic logic [BITCNT_W-1:0] bit_last(input logic [RATE_W-1:0] r);
    bit_last = BITCNT_W'((32'h1 << r) - 32'h1);
  endfunction

  function automatic logic [BITCNT_W-1:0] bit_half(input logic [RATE_W-1:0] r);
    bit_half = BITCNT_W'((32'h1 << r) >> 1);
  endfunction

  ctrl_bus_t   bus_ff;
  logic [7:0]  tune_b0_ff;
  logic [7:0]  tune_b1_ff;
  logic [7:0]  tune_b2_ff;
  logic [TUNE_TOP_W-1:0] tune_b3_ff;
  sync_mode_t  sync_mode_ff;
  out_format_t out_fmt_ff;
  logic        wr_ff;
  logic [3:0]  wr_addr_ff;
  logic [7:0]  wr_data_ff;

  logic        ss_prev_ff;
  logic        as_prev_ff;
  logic        ss_fall_ff;
  logic        as_fall_ff;
  logic [SYNC_LONG-1:0] sync_cnt_ff;
  logic [BITCNT_W-1:0]  bit_cnt_ff;
  logic        frame_hold_ff;
  logic        tune_copy_ff;

  logic [TUNE_W-1:0] tune_word_ff;
  logic        accum_load_ff;
  logic        diag_reinit_ff;
  logic        sync_out_n_ff;
  logic        bit_shift_ff;
  logic        bit_strobe_ff;
  logic        frame_strobe_ff;
  logic [7:0]  data_out_ff;
  logic        data_oe_n_ff;

  logic ss_eff;
  logic term_cnt;
  logic int_sync;
  logic acc_sync;
  logic tune_wr;
  logic load_set;
  logic diag_sync;
  logic bit_end;
  logic [7:0] rd_mux;
  sync_mode_t wr_mode;

  assign tuning_word  = tune_word_ff;
  assign accum_load   = accum_load_ff;
  assign diag_reinit  = diag_reinit_ff;
  assign sync_out_n   = sync_out_n_ff;
  assign bit_shift    = bit_shift_ff;
  assign bit_strobe   = bit_strobe_ff;
  assign frame_strobe = frame_strobe_ff;
  assign data_out     = data_out_ff;
  assign data_oe_n    = data_oe_n_ff;

  // Control bus: a write is taken when cs_n falls with rd_wr_n low
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_ff     <= '{cs_n: 1'b1, rd_wr_n: 1'b1, addr: 4'h0, wdata: 8'h00};
      wr_ff      <= 1'b0;
      wr_addr_ff <= 4'h0;
      wr_data_ff <= 8'h00;
    end
    else
    begin
      bus_ff     <= '{cs_n: cs_n, rd_wr_n: rd_wr_n, addr: addr, wdata: data_in};
      wr_ff      <= bus_ff.cs_n & ~cs_n & ~rd_wr_n;
      wr_addr_ff <= addr;
      wr_data_ff <= data_in;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tune_b0_ff   <= REG_RESET;
      tune_b1_ff   <= REG_RESET;
      tune_b2_ff   <= REG_RESET;
      tune_b3_ff   <= TOP_PAD;
      sync_mode_ff <= sync_mode_t'(REG_RESET);
      out_fmt_ff   <= out_format_t'(REG_RESET);
    end
    else if (wr_ff)
    begin
      case (wr_addr_ff)
        ADDR_TUNE_B0:    tune_b0_ff   <= wr_data_ff;
        ADDR_TUNE_B1:    tune_b1_ff   <= wr_data_ff;
        ADDR_TUNE_B2:    tune_b2_ff   <= wr_data_ff;
        ADDR_TUNE_B3:    tune_b3_ff   <= wr_data_ff[TUNE_TOP_W-1:0];
        ADDR_SYNC_MODE:  sync_mode_ff <= sync_mode_t'(wr_data_ff);
        ADDR_OUT_FORMAT: out_fmt_ff   <= out_format_t'(wr_data_ff);
        default:         ;
      endcase
    end
  end

  always_comb
  begin
    case (bus_ff.addr)
      ADDR_TUNE_B0:    rd_mux = tune_b0_ff;
      ADDR_TUNE_B1:    rd_mux = tune_b1_ff;
      ADDR_TUNE_B2:    rd_mux = tune_b2_ff;
      ADDR_TUNE_B3:    rd_mux = {TOP_PAD, tune_b3_ff};
      ADDR_SYNC_MODE:  rd_mux = sync_mode_ff;
      ADDR_OUT_FORMAT: rd_mux = out_fmt_ff;
      default:         rd_mux = UNMAPPED_READ;
    endcase
  end

  // Data pins are driven only while selected for a read
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      data_oe_n_ff <= 1'b1;
    else
      data_oe_n_ff <= bus_ff.cs_n | ~bus_ff.rd_wr_n;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      data_out_ff <= UNMAPPED_READ;
    else
      data_out_ff <= rd_mux;
  end

  // Sync input edge detection
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ss_prev_ff <= 1'b1;
      as_prev_ff <= 1'b1;
      ss_fall_ff <= 1'b0;
      as_fall_ff <= 1'b0;
    end
    else
    begin
      ss_prev_ff <= sys_sync_in_n;
      as_prev_ff <= accum_sync_in_n;
      ss_fall_ff <= ss_prev_ff & ~sys_sync_in_n;
      as_fall_ff <= as_prev_ff & ~accum_sync_in_n;
    end
  end

  assign ss_eff   = ss_fall_ff & ~sync_mode_ff.sys_sync_disable;
  assign term_cnt = sync_mode_ff.factory_test
                  ? (&sync_cnt_ff[SYNC_SHORT-1:0])
                  : (&sync_cnt_ff);
  assign int_sync = sync_mode_ff.internal_sync_select ? term_cnt : ss_eff;
  assign acc_sync = (sync_mode_ff.sync_source_swap & ~sync_mode_ff.sys_sync_disable)
                  ? ss_eff : as_fall_ff;
  assign diag_sync = sync_mode_ff.diag_sync_enable & int_sync;

  // Internal sync counter free runs; a short period clears it when its low bits are all ones
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sync_cnt_ff <= '0;
    else if (sync_mode_ff.factory_test && term_cnt)
      sync_cnt_ff <= '0;
    else
      sync_cnt_ff <= sync_cnt_ff + 1'b1;
  end

  // Internal sync shown on the active-low output pin
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sync_out_n_ff <= 1'b1;
    else
      sync_out_n_ff <= ~int_sync;
  end

  // Diagnostic sync also reinitialises the accumulator
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      accum_load_ff <= 1'b0;
    else
      accum_load_ff <= (sync_mode_ff.accum_init_enable & acc_sync) | diag_sync;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      diag_reinit_ff <= 1'b0;
    else
      diag_reinit_ff <= diag_sync;
  end

  // Tuning register loads
  assign wr_mode  = sync_mode_t'(wr_data_ff);
  assign tune_wr  = wr_ff && (wr_addr_ff <= ADDR_TUNE_B3);
  assign load_set = wr_ff && (wr_addr_ff == ADDR_SYNC_MODE) && wr_mode.tuning_load
                    && !sync_mode_ff.tuning_load;

  // A byte lands one edge after the write strobe, so the copy waits for it
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tune_copy_ff <= 1'b0;
    else
      tune_copy_ff <= sync_mode_ff.tuning_load && tune_wr;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tune_word_ff <= '0;
    else if (load_set
             || tune_copy_ff
             || (sync_mode_ff.sync_tuning_load && acc_sync))
      tune_word_ff <= {tune_b3_ff, tune_b2_ff, tune_b1_ff, tune_b0_ff};
  end

  // Bit-serial timing
  assign bit_end = (bit_cnt_ff >= bit_last(out_fmt_ff.rate));

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bit_cnt_ff <= '0;
    else if (bit_end || diag_sync)
      bit_cnt_ff <= '0;
    else
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      frame_hold_ff <= 1'b0;
    else if (bit_end)
      frame_hold_ff <= frame_next;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bit_shift_ff <= 1'b0;
    else
      bit_shift_ff <= bit_end;
  end

  // Bit strobe: pulse before each transition, or a clock high in the second half
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bit_strobe_ff <= 1'b0;
    else if (out_fmt_ff.bit_strobe_shape)
      bit_strobe_ff <= out_fmt_ff.bit_strobe_invert
                       ^ (bit_cnt_ff >= bit_half(out_fmt_ff.rate));
    else
      bit_strobe_ff <= out_fmt_ff.bit_strobe_invert ^ bit_end;
  end

  // Frame strobe: pulse before a new frame, or held for its first bit
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      frame_strobe_ff <= 1'b0;
    else if (out_fmt_ff.frame_strobe_shape)
      frame_strobe_ff <= out_fmt_ff.frame_strobe_invert
                         ^ (bit_end ? frame_next : frame_hold_ff);
    else
      frame_strobe_ff <= out_fmt_ff.frame_strobe_invert
                         ^ (bit_end & frame_next);
  end

endmodule

`default_nettype wire

// File: rtl/sync_strobe_pkg.sv
package sync_strobe_pkg;

  // Control bus register addresses
  localparam logic [3:0] ADDR_TUNE_B0    = 4'h0;
  localparam logic [3:0] ADDR_TUNE_B1    = 4'h1;
  localparam logic [3:0] ADDR_TUNE_B2    = 4'h2;
  localparam logic [3:0] ADDR_TUNE_B3    = 4'h3;
  localparam logic [3:0] ADDR_SYNC_MODE  = 4'h4;
  localparam logic [3:0] ADDR_OUT_FORMAT = 4'h5;

  localparam int          TUNE_W        = 28;
  localparam int          TUNE_TOP_W    = 4;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;
  localparam logic [3:0]  TOP_PAD       = 4'h0;

  // Internal sync counter periods as powers of two
  localparam int SYNC_LONG_LOG2  = 20;
  localparam int SYNC_SHORT_LOG2 = 8;

  // Bit serial rate field is four bits wide, so the divider spans 2^15 clocks
  localparam int RATE_W   = 4;
  localparam int BITCNT_W = 15;

  typedef struct packed {
    logic internal_sync_select;
    logic factory_test;
    logic diag_sync_enable;
    logic sync_tuning_load;
    logic tuning_load;
    logic sync_source_swap;
    logic accum_init_enable;
    logic sys_sync_disable;
  } sync_mode_t;

  typedef struct packed {
    logic              frame_strobe_invert;
    logic              frame_strobe_shape;
    logic              bit_strobe_invert;
    logic              bit_strobe_shape;
    logic [RATE_W-1:0] rate;
  } out_format_t;

  typedef struct packed {
    logic       cs_n;
    logic       rd_wr_n;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ctrl_bus_t;

endpackage

// File: verif/sync_strobe_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module sync_strobe_asserts
  import sync_strobe_pkg::*;
#(
  parameter int SYNC_LONG  = SYNC_LONG_LOG2,
  parameter int SYNC_SHORT = SYNC_SHORT_LOG2
)
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              cs_n,
  input wire logic              rd_wr_n,
  input wire logic [3:0]        addr,
  input wire logic [7:0]        data_out,
  input wire logic              data_oe_n,
  input wire logic [TUNE_W-1:0] tuning_word,
  input wire logic              accum_load,
  input wire logic              diag_reinit,
  input wire logic              sync_out_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wr_req;
  logic rd_req;
  assign wr_req = !cs_n && !rd_wr_n;
  assign rd_req = !cs_n && rd_wr_n;
  a_oe_read: assert property (!data_oe_n |-> $past(rd_req, 1) || $past(rd_req, 2))
    else $error("data pins driven without a read");
  a_oe_idle: assert property (cs_n [*3] |-> data_oe_n)
    else $error("data pins driven while idle");
  a_unmapped_zero: assert property (!data_oe_n && $past(addr, 2) > 4'h5 |-> data_out == 8'h00)
    else $error("unmapped read not zero");
  a_top_nibble: assert property (
    !data_oe_n && $past(addr, 2) == 4'h3 |-> data_out[7:4] == 4'h0)
    else $error("tuning byte 3 upper bits not zero");
  a_tune_source: assert property (
    $changed(tuning_word) |-> accum_load || $past(accum_load) || $past(wr_req, 1)
    || $past(wr_req, 2) || $past(wr_req, 3))
    else $error("tuning word changed without cause");
  a_accum_single: assert property (accum_load |=> !accum_load)
    else $error("accum load longer than one cycle");
  a_reinit_single: assert property (diag_reinit |=> !diag_reinit)
    else $error("reinit longer than one cycle");
  a_sync_single: assert property ($fell(sync_out_n) |=> $rose(sync_out_n))
    else $error("sync out longer than one cycle");
endmodule
bind sync_and_serial_strobe_ctrl sync_strobe_asserts #(.SYNC_LONG(SYNC_LONG),
  .SYNC_SHORT(SYNC_SHORT)) u_chk (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
  .rd_wr_n(rd_wr_n), .addr(addr), .data_out(data_out), .data_oe_n(data_oe_n),
  .tuning_word(tuning_word), .accum_load(accum_load), .diag_reinit(diag_reinit),
  .sync_out_n(sync_out_n));
`default_nettype wire

// File: verif/frame_source_model.sv
`timescale 1ns/1ns
`default_nettype none
module frame_source_model
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic bit_shift,
  output logic      frame_next
);
  logic [1:0] bits_ff;
  // Four serial bits make one frame
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      bits_ff <= 2'h0;
    else if (bit_shift)
      bits_ff <= bits_ff + 2'h1;
  assign frame_next = (bits_ff == 2'h3);
endmodule
`default_nettype wire

// File: verif/sync_and_serial_strobe_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sync_and_serial_strobe_ctrl_tb_top;
  import sync_strobe_pkg::*;
  localparam int LONG  = 10;
  localparam int SHORT = 4;
  logic clk, sys_rst, sys_sync_in_n, accum_sync_in_n, frame_next, data_oe_n;
  logic accum_load, diag_reinit, sync_out_n, bit_shift, bit_strobe, frame_strobe;
  logic [7:0] data_out;
  logic [27:0] tuning_word;
  logic [5:0] mon;
  ctrl_bus_t bus;
  int err_count, num_checks;
  logic [7:0] fmt_tab [8] = '{8'h02, 8'h02, 8'h02, 8'h12, 8'h22, 8'h42, 8'hc2, 8'h05};
  int sel_tab [8] = '{3, 4, 5, 4, 4, 5, 5, 3};
  int len_tab [8] = '{16, 16, 64, 16, 16, 64, 64, 64};
  int exp_tab [8] = '{4, 4, 4, 8, 12, 16, 48, 2};
  assign mon = {frame_strobe, bit_strobe, bit_shift, !sync_out_n, diag_reinit, accum_load};
  sync_and_serial_strobe_ctrl #(.SYNC_LONG(LONG), .SYNC_SHORT(SHORT)) dut (.clk(clk),
    .sys_rst(sys_rst), .cs_n(bus.cs_n), .rd_wr_n(bus.rd_wr_n), .addr(bus.addr),
    .data_in(bus.wdata), .data_out(data_out), .data_oe_n(data_oe_n),
    .sys_sync_in_n(sys_sync_in_n), .accum_sync_in_n(accum_sync_in_n),
    .frame_next(frame_next), .tuning_word(tuning_word), .accum_load(accum_load),
    .diag_reinit(diag_reinit), .sync_out_n(sync_out_n), .bit_shift(bit_shift),
    .bit_strobe(bit_strobe), .frame_strobe(frame_strobe));
  frame_source_model partner (.clk(clk), .sys_rst(sys_rst), .bit_shift(bit_shift),
    .frame_next(frame_next));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus = '{1'b0, 1'b0, a, d};
    tick(1);
    bus = '{1'b1, 1'b1, a, d};
    tick(3);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus = '{1'b0, 1'b1, a, 8'h00};
    tick(3);
    chk("data_oe_n", 28'h0, {27'h0, data_oe_n});
    chk("data_out", {20'h0, e}, {20'h0, data_out});
    bus.cs_n = 1'b1;
    tick(3);
  endtask
  // Counts cycles with the chosen output active; sync pins released after two cycles
  task automatic cnt(input string nm, input int sel, input int n, input int e);
    int c;
    c = 0;
    for (int i = 0; i < n; i++)
    begin
      if (i == 2)
      begin
        sys_sync_in_n = 1'b1;
        accum_sync_in_n = 1'b1;
      end
      tick(1);
      if (mon[sel] === 1'b1)
        c++;
    end
    chk(nm, 28'(e), 28'(c));
  endtask
  task automatic spulse(input logic s, input logic a, input string nm, input int sel,
    input int e);
    sys_sync_in_n = !s;
    accum_sync_in_n = !a;
    cnt(nm, sel, 8, e);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #1ms;
    err_count++;
    final_report();
  end
  initial
  begin
    sys_rst = 1'b1;
    bus = '{1'b1, 1'b1, 4'h0, 8'h00};
    sys_sync_in_n = 1'b1;
    accum_sync_in_n = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    tick(1);
    rd(ADDR_SYNC_MODE, REG_RESET);
    rd(ADDR_OUT_FORMAT, REG_RESET);
    wr(4'h6, 8'h5a);
    rd(4'h6, UNMAPPED_READ);
    $display("test registers done");
    wr(ADDR_TUNE_B0, 8'h21);
    wr(ADDR_TUNE_B1, 8'h43);
    wr(ADDR_TUNE_B2, 8'h65);
    wr(ADDR_TUNE_B3, 8'hf7);
    rd(ADDR_TUNE_B3, 8'h07);
    wr(ADDR_SYNC_MODE, 8'h08);
    chk("tuning_word", 28'h7654321, tuning_word);
    wr(ADDR_TUNE_B0, 8'h99);
    chk("tuning_word", 28'h7654399, tuning_word);
    wr(ADDR_TUNE_B0, 8'h99);
    chk("tuning_word", 28'h7654399, tuning_word);
    $display("test tuning load done");
    wr(ADDR_SYNC_MODE, 8'h02);
    spulse(1'b0, 1'b1, "accum_load", 0, 1);
    wr(ADDR_SYNC_MODE, 8'h00);
    spulse(1'b0, 1'b1, "accum_load", 0, 0);
    wr(ADDR_SYNC_MODE, 8'h06);
    spulse(1'b0, 1'b1, "accum_load", 0, 0);
    spulse(1'b1, 1'b0, "accum_load", 0, 1);
    wr(ADDR_SYNC_MODE, 8'h07);
    spulse(1'b1, 1'b0, "accum_load", 0, 0);
    wr(ADDR_SYNC_MODE, 8'h12);
    wr(ADDR_TUNE_B0, 8'h11);
    chk("tuning_word", 28'h7654399, tuning_word);
    spulse(1'b0, 1'b1, "accum_load", 0, 1);
    chk("tuning_word", 28'h7654311, tuning_word);
    $display("test sync sources done");
    wr(ADDR_SYNC_MODE, 8'h20);
    spulse(1'b1, 1'b0, "diag_reinit", 1, 1);
    spulse(1'b1, 1'b0, "sync_out_n", 2, 1);
    wr(ADDR_SYNC_MODE, 8'ha0);
    tick(20);
    cnt("sync_out_n", 2, 2 << LONG, 2);
    wr(ADDR_SYNC_MODE, 8'he0);
    tick(20);
    cnt("sync_out_n", 2, 4 << SHORT, 4);
    cnt("diag_reinit", 1, 4 << SHORT, 4);
    wr(ADDR_SYNC_MODE, 8'h00);
    $display("test diagnostic sync done");
    for (int t = 0; t < 8; t++)
    begin
      wr(ADDR_OUT_FORMAT, fmt_tab[t]);
      tick(80);
      cnt("serial strobe count", sel_tab[t], len_tab[t], exp_tab[t]);
    end
    $display("test serial strobes done");
    final_report();
  end
endmodule
`default_nettype wire
